// File: src/ifsb_top.sv
// Purpose: Interrupt flag status bank, two flag registers on Wishbone
// Assumes: Peripheral requests are synchronous to core_clk; pins are not
// Notes:   Priority and vector logic live elsewhere; one mask word gates irq
//
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/100ps
`default_nettype none
module ifsb_top
  import ifsb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  // DMA requests
  input  wire logic        dma_ch0_req,
  input  wire logic        dma_ch1_req,
  input  wire logic        dma_ch2_req,
  // ADC requests
  input  wire logic        adc_a_req,
  input  wire logic        adc_b_req,
  // UART requests
  input  wire logic        uart_a_tx_req,
  input  wire logic        uart_a_rx_req,
  input  wire logic        uart_b_tx_req,
  input  wire logic        uart_b_rx_req,
  // SPI requests
  input  wire logic        spi_event_req,
  input  wire logic        spi_fault_req,
  // Timer requests
  input  wire logic        timer_a_req,
  input  wire logic        timer_b_req,
  input  wire logic        timer_c_req,
  input  wire logic        timer_d_req,
  input  wire logic        timer_e_req,
  // Output compare requests
  input  wire logic        out_compare_a_req,
  input  wire logic        out_compare_b_req,
  input  wire logic        out_compare_c_req,
  input  wire logic        out_compare_d_req,
  // Input capture requests
  input  wire logic        in_capture_a_req,
  input  wire logic        in_capture_b_req,
  input  wire logic        in_capture_g_req,
  input  wire logic        in_capture_h_req,
  // External interrupt pins, asynchronous
  input  wire logic        ext_pin_a,
  input  wire logic        ext_pin_b,
  input  wire logic        ext_pin_c,
  // Change notification and I2C
  input  wire logic        change_notify_req,
  input  wire logic        i2c_master_event_req,
  input  wire logic        i2c_slave_event_req,
  // Flags to priority logic and interrupt
  output logic [15:0]      interrupt_flags_0,
  output logic [15:0]      interrupt_flags_1,
  output logic             irq
);

  // Byte-lane merge of a 16-bit register, lanes 0 and 1 only
  // Lanes 2 and 3 carry nothing, so writes there are dropped
  function automatic logic [15:0] lane_merge(input logic [15:0] old_v,
                                             input logic [15:0] new_v,
                                             input logic [3:0]  sel);
    lane_merge = {sel[1] ? new_v[15:8] : old_v[15:8],
                  sel[0] ? new_v[7:0]  : old_v[7:0]};
  endfunction

  // Bus state
  logic        ack_r;        // Ack, one cycle per request
  logic        err_r;        // Error for unmapped address
  logic [31:0] rdata_r;      // Registered read data
  logic [2:0]  polarity_r;   // Pin edge polarity selects
  logic [15:0] mask_r;       // Interrupt mask over flags 0
  logic [15:0] mask1_r;      // Interrupt mask over flags 1
  logic [15:0] flags0;       // Flags 0 state
  logic [15:0] flags1;       // Flags 1 state

  // Decode, accept only when not already answering
  // A request is refused while its answer still stands
  wire req_go      = wb_cyc_i & wb_stb_i & ~ack_r & ~err_r;
  wire hit_flags0  = (wb_adr_i == FLAGS0_OFS);
  wire hit_flags1  = (wb_adr_i == FLAGS1_OFS);
  wire hit_pol     = (wb_adr_i == POLARITY_OFS);
  wire hit_mask    = (wb_adr_i == IRQ_MASK_OFS);
  wire hit_any     = hit_flags0 | hit_flags1 | hit_pol | hit_mask;
  wire wr_go       = req_go & wb_we_i & hit_any;
  wire wr_flags0   = wr_go & hit_flags0;
  wire wr_flags1   = wr_go & hit_flags1;

  // Write data after byte-lane merge
  wire [15:0] wdata0 = lane_merge(flags0, wb_dat_i[15:0], wb_sel_i);
  wire [15:0] wdata1 = lane_merge(flags1, wb_dat_i[15:0], wb_sel_i);

  // Pin edge pulses
  // Pins are asynchronous; each detector synchronises first
  logic pin_a_edge;
  logic pin_b_edge;
  logic pin_c_edge;

  ifsb_edge_detect u_pin_a (
    .core_clk    (core_clk),
    .rst         (rst),
    .pin_in      (ext_pin_a),
    .falling_sel (polarity_r[0]),
    .edge_pulse  (pin_a_edge)
  );
  ifsb_edge_detect u_pin_b (
    .core_clk    (core_clk),
    .rst         (rst),
    .pin_in      (ext_pin_b),
    .falling_sel (polarity_r[1]),
    .edge_pulse  (pin_b_edge)
  );
  ifsb_edge_detect u_pin_c (
    .core_clk    (core_clk),
    .rst         (rst),
    .pin_in      (ext_pin_c),
    .falling_sel (polarity_r[2]),
    .edge_pulse  (pin_c_edge)
  );

  // Source positions in vector order
  logic [15:0] set0;
  logic [15:0] set1;
  always_comb begin
    set0 = 16'h0000;
    set0[EXT_PIN_A_BIT]  = pin_a_edge;
    set0[IN_CAP_A_BIT]   = in_capture_a_req;
    set0[OUT_CMP_A_BIT]  = out_compare_a_req;
    set0[TIMER_A_BIT]    = timer_a_req;
    set0[DMA_CH0_BIT]    = dma_ch0_req;
    set0[IN_CAP_B_BIT]   = in_capture_b_req;
    set0[OUT_CMP_B_BIT]  = out_compare_b_req;
    set0[TIMER_B_BIT]    = timer_b_req;
    set0[TIMER_C_BIT]    = timer_c_req;
    set0[SPI_FAULT_BIT]  = spi_fault_req;
    set0[SPI_EVENT_BIT]  = spi_event_req;
    set0[UART_A_RX_BIT]  = uart_a_rx_req;
    set0[UART_A_TX_BIT]  = uart_a_tx_req;
    set0[ADC_A_BIT]      = adc_a_req;
    set0[DMA_CH1_BIT]    = dma_ch1_req;
    set1 = 16'h0000;
    set1[I2C_SLAVE_BIT]  = i2c_slave_event_req;
    set1[I2C_MASTER_BIT] = i2c_master_event_req;
    set1[CHANGE_BIT]     = change_notify_req;
    set1[EXT_PIN_B_BIT]  = pin_b_edge;
    set1[ADC_B_BIT]      = adc_b_req;
    set1[IN_CAP_G_BIT]   = in_capture_g_req;
    set1[IN_CAP_H_BIT]   = in_capture_h_req;
    set1[DMA_CH2_BIT]    = dma_ch2_req;
    set1[OUT_CMP_C_BIT]  = out_compare_c_req;
    set1[OUT_CMP_D_BIT]  = out_compare_d_req;
    set1[TIMER_D_BIT]    = timer_d_req;
    set1[TIMER_E_BIT]    = timer_e_req;
    set1[EXT_PIN_C_BIT]  = pin_c_edge;
    set1[UART_B_RX_BIT]  = uart_b_rx_req;
    set1[UART_B_TX_BIT]  = uart_b_tx_req;
  end

  // Flag registers
  // A source request wins over a clearing write in one cycle
  ifsb_flag_reg u_flags0 (
    .core_clk  (core_clk),
    .rst       (rst),
    .set_req   (set0),
    .wr_en     (wr_flags0),
    .wr_data   (wdata0),
    .impl_mask (FLAGS0_IMPL),
    .flags     (flags0)
  );
  ifsb_flag_reg u_flags1 (
    .core_clk  (core_clk),
    .rst       (rst),
    .set_req   (set1),
    .wr_en     (wr_flags1),
    .wr_data   (wdata1),
    .impl_mask (FLAGS1_IMPL),
    .flags     (flags1)
  );

  // Read mux, upper bits zero
  wire [15:0] rd_mux = hit_flags0 ? flags0 :
                       hit_flags1 ? flags1 :
                       hit_pol    ? {13'h0, polarity_r} :
                       hit_mask   ? mask_r : 16'h0000;

  // Bus answer: one cycle after request, dropped next cycle
  // Read data is zero outside a read answer
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_r   <= 1'b0;
      err_r   <= 1'b0;
      rdata_r <= 32'h0000_0000;
    end else begin
      ack_r   <= req_go & hit_any;
      err_r   <= req_go & ~hit_any;
      rdata_r <= (req_go & ~wb_we_i) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  // Control registers: polarity and mask
  always_ff @(posedge core_clk) begin
    if (rst) begin
      polarity_r <= POLARITY_RST;
      mask_r     <= MASK_RST;
    end else begin
      if (wr_go & hit_pol & wb_sel_i[0]) begin
        polarity_r <= wb_dat_i[2:0];
      end
      if (wr_go & hit_mask) begin
        mask_r <= lane_merge(mask_r, wb_dat_i[15:0], wb_sel_i);
      end
    end
  end

  // Mask applies to all 16 bits of flags 0 and to flags 1 via the same word
  assign mask1_r = mask_r;

  assign wb_ack_o          = ack_r;
  assign wb_err_o          = err_r;
  assign wb_dat_o          = rdata_r;
  assign interrupt_flags_0 = flags0;
  assign interrupt_flags_1 = flags1;
  // Level interrupt, held until software clears the flag
  assign irq = |(flags0 & mask_r) | |(flags1 & mask1_r);

  // Assertions
  sequence req_seen_s;
    !rst && wb_cyc_i && wb_stb_i && !ack_r && !err_r;
  endsequence

  ack_one_cycle_a : assert property (@(posedge core_clk) disable iff (rst)
    wb_ack_o |=> !wb_ack_o) else $error("ack held over two cycles");
  ack_follows_req_a : assert property (@(posedge core_clk) disable iff (rst)
    req_seen_s ##0 hit_any |=> wb_ack_o) else $error("mapped request not acked");
  flag0_unimpl_a : assert property (@(posedge core_clk) disable iff (rst)
    !interrupt_flags_0[15]) else $error("flags0 bit 15 set");
  flag1_unimpl_a : assert property (@(posedge core_clk) disable iff (rst)
    !interrupt_flags_1[2]) else $error("flags1 bit 2 set");
  dma_sets_flag_a : assert property (@(posedge core_clk) disable iff (rst)
    dma_ch1_req |=> interrupt_flags_0[DMA_CH1_BIT]) else $error("dma ch1 flag missed");
  uart_sets_flag_a : assert property (@(posedge core_clk) disable iff (rst)
    uart_b_tx_req |=> interrupt_flags_1[UART_B_TX_BIT]) else $error("uart b tx flag missed");
  flag_sticky_a : assert property (@(posedge core_clk) disable iff (rst)
    interrupt_flags_0[TIMER_A_BIT] && !wr_flags0 |=> interrupt_flags_0[TIMER_A_BIT])
    else $error("flag dropped without write");
  change_sets_a : assert property (@(posedge core_clk) disable iff (rst)
    change_notify_req |=> interrupt_flags_1[CHANGE_BIT]) else $error("change flag missed");
  reset_clears_a : assert property (@(posedge core_clk)
    rst |=> interrupt_flags_0 == 16'h0000 && interrupt_flags_1 == 16'h0000)
    else $error("flags not cleared by reset");
  pin_edge_sets_a : assert property (@(posedge core_clk) disable iff (rst)
    pin_a_edge |=> interrupt_flags_0[EXT_PIN_A_BIT]) else $error("pin a flag missed");

  // Write to a flag register with no request in the same cycle
  sequence flag0_write_s;
    wr_flags0 && set0 == 16'h0000;
  endsequence
  sequence flag1_write_s;
    wr_flags1 && set1 == 16'h0000;
  endsequence
  // Taken request to an unmapped place
  sequence req_stray_s;
    req_seen_s ##0 !hit_any;
  endsequence
  err_unmapped_a : assert property (@(posedge core_clk) disable iff (rst)
    req_stray_s |=> wb_err_o && !wb_ack_o)
    else $error("unmapped request not refused");
  answer_excl_a : assert property (@(posedge core_clk) disable iff (rst)
    !(wb_ack_o && wb_err_o))
    else $error("ack and err together");
  upper_zero_a : assert property (@(posedge core_clk) disable iff (rst)
    wb_dat_o[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  write0_lands_a : assert property (@(posedge core_clk) disable iff (rst)
    flag0_write_s |=> interrupt_flags_0 == ($past(wdata0) & FLAGS0_IMPL))
    else $error("flags0 write lost");
  write1_lands_a : assert property (@(posedge core_clk) disable iff (rst)
    flag1_write_s |=> interrupt_flags_1 == ($past(wdata1) & FLAGS1_IMPL))
    else $error("flags1 write lost");
  req0_lands_a : assert property (@(posedge core_clk) disable iff (rst)
    set0 != 16'h0000 |=> (interrupt_flags_0 & $past(set0) & FLAGS0_IMPL) == ($past(set0) & FLAGS0_IMPL))
    else $error("flags0 request lost");
  req1_lands_a : assert property (@(posedge core_clk) disable iff (rst)
    set1 != 16'h0000 |=> (interrupt_flags_1 & $past(set1) & FLAGS1_IMPL) == ($past(set1) & FLAGS1_IMPL))
    else $error("flags1 request lost");
  no_spurious0_a : assert property (@(posedge core_clk) disable iff (rst)
    !$past(wr_flags0) |-> (interrupt_flags_0 & ~$past(interrupt_flags_0) & ~$past(set0)) == 16'h0000)
    else $error("flags0 bit rose without request");
  no_spurious1_a : assert property (@(posedge core_clk) disable iff (rst)
    !$past(wr_flags1) |-> (interrupt_flags_1 & ~$past(interrupt_flags_1) & ~$past(set1)) == 16'h0000)
    else $error("flags1 bit rose without request");
  // Each source class lands in its own bit
  adc_sets_flag_a : assert property (@(posedge core_clk) disable iff (rst)
    adc_b_req |=> interrupt_flags_1[ADC_B_BIT])
    else $error("adc b flag missed");
  spi_sets_flag_a : assert property (@(posedge core_clk) disable iff (rst)
    spi_fault_req |=> interrupt_flags_0[SPI_FAULT_BIT])
    else $error("spi fault flag missed");
  timer_sets_flag_a : assert property (@(posedge core_clk) disable iff (rst)
    timer_e_req |=> interrupt_flags_1[TIMER_E_BIT])
    else $error("timer e flag missed");
  cmp_sets_flag_a : assert property (@(posedge core_clk) disable iff (rst)
    out_compare_d_req |=> interrupt_flags_1[OUT_CMP_D_BIT])
    else $error("compare d flag missed");
  cap_sets_flag_a : assert property (@(posedge core_clk) disable iff (rst)
    in_capture_g_req |=> interrupt_flags_1[IN_CAP_G_BIT])
    else $error("capture g flag missed");
  i2c_sets_flag_a : assert property (@(posedge core_clk) disable iff (rst)
    i2c_master_event_req |=> interrupt_flags_1[I2C_MASTER_BIT])
    else $error("i2c master flag missed");
  pin_c_sets_a : assert property (@(posedge core_clk) disable iff (rst)
    pin_c_edge |=> interrupt_flags_1[EXT_PIN_C_BIT])
    else $error("pin c flag missed");
  pol_write_a : assert property (@(posedge core_clk) disable iff (rst)
    wr_go && hit_pol && wb_sel_i[0] |=> polarity_r == $past(wb_dat_i[2:0]))
    else $error("polarity write lost");
endmodule
`default_nettype wire

// File: src/ifsb_pkg.sv
// Purpose: Shared constants for the interrupt flag status bank
// Assumes: Classic Wishbone, 32-bit data, word aligned registers
// Notes:   Flag layouts follow natural vector order of the sources
package ifsb_pkg;
  // Register byte offsets
  localparam logic [3:0]  FLAGS0_OFS    = 4'h0;
  localparam logic [3:0]  FLAGS1_OFS    = 4'h4;
  localparam logic [3:0]  POLARITY_OFS  = 4'h8;
  localparam logic [3:0]  IRQ_MASK_OFS  = 4'hc;
  // Reset values
  localparam logic [15:0] FLAGS_RST     = 16'h0000;
  localparam logic [2:0]  POLARITY_RST  = 3'h0;
  localparam logic [15:0] MASK_RST      = 16'h0000;
  // Implemented bits: bit 15 of flags 0 and bit 2 of flags 1 absent
  localparam logic [15:0] FLAGS0_IMPL   = 16'h7fff;
  localparam logic [15:0] FLAGS1_IMPL   = 16'hfffb;
  // Flag 0 positions
  localparam int EXT_PIN_A_BIT   = 0;
  localparam int IN_CAP_A_BIT    = 1;
  localparam int OUT_CMP_A_BIT   = 2;
  localparam int TIMER_A_BIT     = 3;
  localparam int DMA_CH0_BIT     = 4;
  localparam int IN_CAP_B_BIT    = 5;
  localparam int OUT_CMP_B_BIT   = 6;
  localparam int TIMER_B_BIT     = 7;
  localparam int TIMER_C_BIT     = 8;
  localparam int SPI_FAULT_BIT   = 9;
  localparam int SPI_EVENT_BIT   = 10;
  localparam int UART_A_RX_BIT   = 11;
  localparam int UART_A_TX_BIT   = 12;
  localparam int ADC_A_BIT       = 13;
  localparam int DMA_CH1_BIT     = 14;
  // Flag 1 positions
  localparam int I2C_SLAVE_BIT   = 0;
  localparam int I2C_MASTER_BIT  = 1;
  localparam int CHANGE_BIT      = 3;
  localparam int EXT_PIN_B_BIT   = 4;
  localparam int ADC_B_BIT       = 5;
  localparam int IN_CAP_G_BIT    = 6;
  localparam int IN_CAP_H_BIT    = 7;
  localparam int DMA_CH2_BIT     = 8;
  localparam int OUT_CMP_C_BIT   = 9;
  localparam int OUT_CMP_D_BIT   = 10;
  localparam int TIMER_D_BIT     = 11;
  localparam int TIMER_E_BIT     = 12;
  localparam int EXT_PIN_C_BIT   = 13;
  localparam int UART_B_RX_BIT   = 14;
  localparam int UART_B_TX_BIT   = 15;
endpackage

// File: src/ifsb_edge_detect.sv
// Purpose: Synchronise one external pin and detect the selected edge
// Assumes: Pin is asynchronous to core_clk
// Notes:   Pulse is one cycle, two edges after the pin moves
`timescale 1ns/100ps
`default_nettype none
module ifsb_edge_detect
  import ifsb_pkg::*;
(
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Pin and polarity
  input  wire logic pin_in,
  input  wire logic falling_sel,
  // Result
  output logic      edge_pulse
);
  logic sync1_r;  // First stage, read only by sync2_r and the edge assertions
  logic sync2_r;  // Second stage
  logic last_r;   // Previous synchronised level

  // Two-stage synchroniser and history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      last_r  <= 1'b0;
    end else begin
      sync1_r <= pin_in;
      sync2_r <= sync1_r;
      last_r  <= sync2_r;
    end
  end

  // Falling when select is 1, rising when 0
  assign edge_pulse = falling_sel ? (last_r & ~sync2_r) : (~last_r & sync2_r);

  // First stage moves, pulse follows one edge later
  sequence pin_rise_s;
    !sync1_r ##1 sync1_r;
  endsequence
  sequence pin_fall_s;
    sync1_r ##1 !sync1_r;
  endsequence
  rise_pulse_a : assert property (@(posedge core_clk) disable iff (rst)
    pin_rise_s |=> edge_pulse || falling_sel)
    else $error("rising edge missed");
  fall_pulse_a : assert property (@(posedge core_clk) disable iff (rst)
    pin_fall_s |=> edge_pulse || !falling_sel)
    else $error("falling edge missed");
endmodule
`default_nettype wire

// File: src/ifsb_flag_reg.sv
// Purpose: One 16-bit sticky flag register with software access
// Assumes: Requests are single-cycle or level, same clock domain
// Notes:   Hardware set wins over software clear in the same cycle
`timescale 1ns/100ps
`default_nettype none
module ifsb_flag_reg
  import ifsb_pkg::*;
(
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Source requests and software write
  input  wire logic [15:0] set_req,
  input  wire logic        wr_en,
  input  wire logic [15:0] wr_data,
  input  wire logic [15:0] impl_mask,
  // Flag state
  output logic [15:0]      flags
);
  logic [15:0] flags_r;    // Stored flags
  logic [15:0] flags_nxt;  // Next flags

  // Write replaces stored value; requests then OR in on top
  assign flags_nxt = ((wr_en ? wr_data : flags_r) | set_req) & impl_mask;

  // Flags clear at reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= flags_nxt;
    end
  end

  assign flags = flags_r;
endmodule
`default_nettype wire

// File: bench/ifsb_periph_model.sv
// Purpose: Peripheral side model raising interrupt requests
// Assumes: Bench sets command levels by NBA at rising edges
// Notes:   A held command gives one pulse, like a real source
`timescale 1ns/100ps
`default_nettype none
module ifsb_periph_model (
  // Clock
  input  wire logic        core_clk,
  // Commands from the bench
  input  wire logic [15:0] fire0,
  input  wire logic [15:0] fire1,
  input  wire logic [2:0]  pin_lvl,
  // Request lines and pins
  output logic [15:0]      req0,
  output logic [15:0]      req1,
  output logic [2:0]       pins
);
  logic [15:0] fire0_r;  // Previous command, bank 0
  logic [15:0] fire1_r;  // Previous command, bank 1
  // Remember commands for edge finding
  always_ff @(posedge core_clk) begin
    fire0_r <= fire0;
    fire1_r <= fire1;
  end
  // One pulse per command, so stickiness is really tested
  assign req0 = fire0 & ~fire0_r;
  assign req1 = fire1 & ~fire1_r;
  // Pins are asynchronous levels
  assign pins = pin_lvl;
endmodule
`default_nettype wire

// File: bench/ifsb_top_test.sv
// Purpose: Self-checking bench for the flag status bank
// Assumes: Wishbone classic master, one request at a time
// Notes:   Bus answers are checked from a queue by a monitor
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module ifsb_top_test
  import ifsb_pkg::*;
  ;
  logic        core_clk, rst;                // Clock and reset
  logic        wb_cyc, wb_stb, wb_we;        // Bus request
  logic [3:0]  wb_adr, wb_sel;               // Bus address and lanes
  logic [31:0] wb_dat, wb_dat_o, v;          // Bus data, random set
  logic        wb_ack_o, wb_err_o, irq;      // Bus answer, interrupt
  logic [15:0] fire0, fire1, req0, req1;     // Model commands, requests
  logic [15:0] flags0, flags1;               // Flag outputs
  logic [2:0]  pin_lvl, pins;                // Pin levels
  logic [3:0]  sel_v;                        // Lanes for the next request
  logic [33:0] e;                            // Oldest expectation
  logic [33:0] exp_q[$];                     // Expected answers
  int          n_mismatch, tests_run, cycles;
  ifsb_periph_model u_ifsb_periph_model (.core_clk(core_clk), .fire0(fire0), .fire1(fire1),
    .pin_lvl(pin_lvl), .req0(req0), .req1(req1), .pins(pins));
  // Request indices follow the flag layout
  ifsb_top u_ifsb_top (.core_clk(core_clk), .rst(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .dma_ch0_req(req0[4]), .dma_ch1_req(req0[14]), .dma_ch2_req(req1[8]),
    .adc_a_req(req0[13]), .adc_b_req(req1[5]),
    .uart_a_tx_req(req0[12]), .uart_a_rx_req(req0[11]), .uart_b_tx_req(req1[15]), .uart_b_rx_req(req1[14]),
    .spi_event_req(req0[10]), .spi_fault_req(req0[9]),
    .timer_a_req(req0[3]), .timer_b_req(req0[7]), .timer_c_req(req0[8]),
    .timer_d_req(req1[11]), .timer_e_req(req1[12]),
    .out_compare_a_req(req0[2]), .out_compare_b_req(req0[6]),
    .out_compare_c_req(req1[9]), .out_compare_d_req(req1[10]),
    .in_capture_a_req(req0[1]), .in_capture_b_req(req0[5]),
    .in_capture_g_req(req1[6]), .in_capture_h_req(req1[7]),
    .ext_pin_a(pins[0]), .ext_pin_b(pins[1]), .ext_pin_c(pins[2]),
    .change_notify_req(req1[3]), .i2c_master_event_req(req1[1]), .i2c_slave_event_req(req1[0]),
    .interrupt_flags_0(flags0), .interrupt_flags_1(flags1), .irq(irq));
  // Print verdict and stop
  task automatic final_report();
    if (n_mismatch == 0 && tests_run > 0 && exp_q.size() == 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // One classic cycle; held until ack or err is sampled
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      input logic [31:0] x, input logic er);
    int n;
    n = 0;
    exp_q.push_back({~w, er, x});
    wb_cyc <= 1'h1;
    wb_stb <= 1'h1;
    wb_we  <= w;
    wb_adr <= a;
    wb_sel <= sel_v;
    wb_dat <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (wb_ack_o !== 1'h1 && wb_err_o !== 1'h1 && n < 40);
    if (n >= 40) n_mismatch++;
    wb_cyc <= 1'h0;
    wb_stb <= 1'h0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] x);
    xfer(1'h0, a, 32'h0, x, 1'h0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    xfer(1'h1, a, d, 32'h0, 1'h0);
  endtask
  task automatic clr();
    wr(FLAGS0_OFS, 32'h0);
    wr(FLAGS1_OFS, 32'h0);
  endtask
  // Command a set of sources, held a random while
  task automatic fire(input logic [31:0] s);
    {fire1, fire0} <= s;
    repeat (1 + $urandom() % 4) @(posedge core_clk);
    {fire1, fire0} <= 32'h0;
    @(posedge core_clk);
  endtask
  task automatic pin_to(input logic [2:0] l);
    pin_lvl <= l;
    repeat (8) @(posedge core_clk);
  endtask
  // Clock, 5 ns period
  initial begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Monitor: match each bus answer to the oldest note
  always @(posedge core_clk) begin
    if (wb_ack_o === 1'h1 || wb_err_o === 1'h1) begin
      if (exp_q.size() == 0) n_mismatch++;
      else begin
        e = exp_q.pop_front();
        `CHK("wb_err", e[32], wb_err_o)
        if (e[33]) `CHK("wb_dat", e[31:0], wb_dat_o)
      end
    end
  end
  // Hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 6000) begin
      n_mismatch++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    {rst, wb_cyc, wb_stb, wb_we, wb_adr, wb_dat, fire0, fire1, pin_lvl} = {1'h1, 74'h0};
    {wb_sel, sel_v} = 8'h33;
    void'($urandom(52434));
    repeat (6) @(posedge core_clk);
    rst <= 1'h0;
    @(posedge core_clk);
    rd(FLAGS0_OFS, 32'h0);
    rd(FLAGS1_OFS, 32'h0);
    rd(POLARITY_OFS, 32'h0);
    rd(IRQ_MASK_OFS, 32'h0);
    wr(FLAGS0_OFS, 32'hffffffff);
    wr(FLAGS1_OFS, 32'hffffffff);
    rd(FLAGS0_OFS, 32'h7fff);
    rd(FLAGS1_OFS, 32'hfffb);
    clr();
    rd(FLAGS0_OFS, 32'h0);
    rd(FLAGS1_OFS, 32'h0);
    // Byte lanes: only the selected half is written
    sel_v = 4'h1;
    wr(FLAGS0_OFS, 32'hffff);
    sel_v = 4'h2;
    wr(FLAGS1_OFS, 32'hffff);
    sel_v = 4'h3;
    rd(FLAGS0_OFS, 32'h00ff);
    rd(FLAGS1_OFS, 32'hff00);
    clr();
    // Each request source alone must land in its own bit only
    for (int i = 0; i < 32; i++) begin
      if ({16'hdfeb, 16'h7ffe} >> i & 32'h1) begin
        fire(32'h1 << i);
        rd(i < 16 ? FLAGS0_OFS : FLAGS1_OFS, 32'h1 << (i % 16));
        clr();
      end
    end
    // Random groups stay set after the requests end
    repeat (6) begin
      v = $urandom() & {16'hdfeb, 16'h7ffe};
      fire(v);
      repeat ($urandom() % 8) @(posedge core_clk);
      `CHK("flags0", v[15:0], flags0)
      `CHK("flags1", v[31:16], flags1)
      rd(FLAGS0_OFS, {16'h0, v[15:0]});
      rd(FLAGS1_OFS, {16'h0, v[31:16]});
      clr();
    end
    // Pins: rising edges set when polarity is 0
    pin_to(3'h7);
    rd(FLAGS0_OFS, 32'h1);
    rd(FLAGS1_OFS, 32'h2010);
    clr();
    pin_to(3'h0);
    rd(FLAGS0_OFS, 32'h0);
    rd(FLAGS1_OFS, 32'h0);
    wr(POLARITY_OFS, 32'h7);
    rd(POLARITY_OFS, 32'h7);
    pin_to(3'h7);
    rd(FLAGS1_OFS, 32'h0);
    pin_to(3'h0);
    rd(FLAGS0_OFS, 32'h1);
    rd(FLAGS1_OFS, 32'h2010);
    clr();
    // Interrupt follows unmasked flags only
    wr(IRQ_MASK_OFS, 32'h8);
    rd(IRQ_MASK_OFS, 32'h8);
    fire(32'h10000);
    `CHK("irq masked", 1'h0, irq)
    fire(32'h8);
    `CHK("irq raised", 1'h1, irq)
    clr();
    `CHK("irq cleared", 1'h0, irq)
    // Unmapped place answers with error, no side effect
    xfer(1'h1, 4'h6, 32'hffff, 32'h0, 1'h1);
    xfer(1'h0, 4'h6, 32'h0, 32'h0, 1'h1);
    rd(FLAGS0_OFS, 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
